// ===== core/aob_pkg.sv
// constants and types shared by the result byte output block
package aob_pkg;
    localparam int RESULT_W = 12;
    localparam int BYTE_W = 8;
    localparam int HIGH_W = 6;
    // start of integrate trails the run request by seven clock periods
    localparam int START_DELAY_CYCLES = 7;
    localparam logic [2:0] START_DELAY_LAST = 3'(START_DELAY_CYCLES - 1);
    localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
    localparam logic STROBE_IDLE = 1'b1;
    // one internal converter clock period is two system clocks (one phase each)
    localparam logic [0:0] PHASE_RISE = 1'b0;
    localparam logic [0:0] PHASE_FALL = 1'b1;

    typedef enum logic [2:0] {
        AOB_IDLE,
        AOB_WAIT_HIGH,
        AOB_LOAD_HIGH,
        AOB_HOLD_HIGH,
        AOB_LOAD_LOW,
        AOB_HOLD_LOW,
        AOB_FINISH
    } aob_hs_state_type;
endpackage

// ===== core/aob_edge_detect.sv
// synchroniser with rising edge detector for the mode input
module aob_edge_detect (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~prev_q;
endmodule

// ===== core/aob_result_output.sv
// result latch, direct byte access and two-byte handshake sequencer
// Notes on behaviour
// - gate low in auto-zero halts there; integrate starts seven clocks after gate high.
// - low byte holds result bits 1-8; high byte bits 9-12, sign, overrange.
// - direct mode select and byte enables are active low, idle high when open.
// - direct mode drives a byte only while select and its enable are low.
// - direct enables are asynchronous; readers use status to read coherent data.
// - output latch contents never change while status is low.
// - mode held high enters handshake after each new result is latched.
// - rising edge of mode pulse enters handshake at any point.
// - trigger during latch update waits until stored data is stable.
// - in handshake mode input ignored, conversions continue, new results dropped.
// - handshake active or mode high makes strobe and enables outputs.
// - buffer-empty input sampled on falling internal edge, incl. entry edge.
// - rising edge after empty sensed drives load, high enable low, high data on.
// - load low one period, data one and half, enable two periods.
// - low byte follows with load and low enable; handshake ends after both.
// - buffer-empty low after high byte halts with high enable and data held.
// - empty returns: data off at fall, half later swap to low byte.
// - after low byte: data off at empty fall, half later clear, strobes high.
// - empty low at entry gates the high byte like the low byte.
// - status rises at integrate start, falls half a period after latching.
// - mode input has weak pulldown; low or open selects direct mode.
module aob_result_output
    import aob_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [aob_pkg::RESULT_W-1:0] conv_result,
    input wire logic conv_sign,
    input wire logic conv_overrange,
    input wire logic conv_done,
    input wire logic autozero_end,
    input wire logic convert_gate,
    input wire logic mode_in,
    input wire logic tx_buffer_empty,
    input wire logic select_n_in,
    input wire logic high_byte_enable_n_in,
    input wire logic low_byte_enable_n_in,
    output logic integrate_start,
    output logic conv_status,
    output logic handshake_active,
    output logic [aob_pkg::BYTE_W-1:0] low_byte_out,
    output logic low_byte_oe,
    output logic [aob_pkg::HIGH_W-1:0] high_byte_out,
    output logic high_byte_oe,
    output logic select_n_out,
    output logic high_byte_enable_n_out,
    output logic low_byte_enable_n_out,
    output logic strobes_oe
);
    import aob_pkg::*;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // internal clock phase and mode input
    // ----------------------------------------------------------------
    logic phase_q;
    logic mode_level;
    logic mode_rise;
    logic fall_edge;
    logic rise_edge;

    // each clk_sys edge stands for one internal clock edge, alternating fall and rise
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phase_q <= PHASE_RISE;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    assign fall_edge = (phase_q == PHASE_FALL);
    assign rise_edge = (phase_q == PHASE_RISE);

    // the pulldown on the pin is external; an open pin reads low here
    aob_edge_detect u_mode_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .async_in(mode_in),
        .level_out(mode_level),
        .rise_out(mode_rise)
    );

    // ----------------------------------------------------------------
    // hold in auto-zero and start delay
    // ----------------------------------------------------------------
    logic holding_q;
    logic [2:0] start_cnt_q;
    logic counting_q;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            holding_q <= 1'b0;
            counting_q <= 1'b0;
            start_cnt_q <= 3'h0;
            integrate_start <= 1'b0;
        end else begin
            integrate_start <= 1'b0;
            if (autozero_end && !counting_q) begin
                holding_q <= 1'b1;
                counting_q <= 1'b0;
            end
            if (holding_q && convert_gate && !counting_q) begin
                counting_q <= 1'b1;
                start_cnt_q <= 3'h0;
            end
            // the delay is counted in converter periods, one per rise phase
            if (counting_q && rise_edge) begin
                if (start_cnt_q == START_DELAY_LAST) begin
                    counting_q <= 1'b0;
                    holding_q <= 1'b0;
                    integrate_start <= 1'b1;
                end else begin
                    start_cnt_q <= start_cnt_q + 3'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // output latch and status
    // ----------------------------------------------------------------
    logic [RESULT_W-1:0] result_q;
    logic sign_bit_q;
    logic overrange_q;
    logic latch_pulse_q;
    logic hs_q;
    logic status_drop_q;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            result_q <= RESULT_RESET;
            sign_bit_q <= 1'b0;
            overrange_q <= 1'b0;
            latch_pulse_q <= 1'b0;
        end else begin
            latch_pulse_q <= 1'b0;
            // status is still high here, so data only moves while it is high
            if (conv_done && !hs_q && conv_status) begin
                result_q <= conv_result;
                sign_bit_q <= conv_sign;
                overrange_q <= conv_overrange;
                latch_pulse_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            conv_status <= 1'b0;
            status_drop_q <= 1'b0;
        end else begin
            status_drop_q <= 1'b0;
            if (integrate_start) begin
                conv_status <= 1'b1;
            end else if (conv_done && conv_status) begin
                status_drop_q <= 1'b1;
            end else if (status_drop_q) begin
                conv_status <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // handshake sequencer
    // ----------------------------------------------------------------
    aob_hs_state_type state_q;
    logic pending_q;
    logic empty_q;

    // a trigger during a latch update waits for the data to settle
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pending_q <= 1'b0;
        end else if (hs_q) begin
            pending_q <= 1'b0;
        end else if (mode_rise || (latch_pulse_q && mode_level)) begin
            pending_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            empty_q <= 1'b0;
        end else if (fall_edge) begin
            empty_q <= tx_buffer_empty;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= AOB_IDLE;
            hs_q <= 1'b0;
        end else begin
            unique case (state_q)
                AOB_IDLE: begin
                    if (fall_edge && pending_q && !latch_pulse_q && !conv_done) begin
                        hs_q <= 1'b1;
                        state_q <= AOB_WAIT_HIGH;
                    end
                end
                AOB_WAIT_HIGH: begin
                    if (rise_edge && empty_q) begin
                        state_q <= AOB_LOAD_HIGH;
                    end
                end
                AOB_LOAD_HIGH: begin
                    // one full period of load low: rise to next rise
                    if (rise_edge) begin
                        state_q <= AOB_HOLD_HIGH;
                    end
                end
                AOB_HOLD_HIGH: begin
                    if (fall_edge && tx_buffer_empty) begin
                        state_q <= AOB_LOAD_LOW;
                    end
                end
                AOB_LOAD_LOW: begin
                    // first rise starts the low load, the next rise ends it
                    if (rise_edge && !select_n_out) begin
                        state_q <= AOB_HOLD_LOW;
                    end
                end
                AOB_HOLD_LOW: begin
                    if (fall_edge && tx_buffer_empty) begin
                        state_q <= AOB_FINISH;
                    end
                end
                AOB_FINISH: begin
                    state_q <= AOB_IDLE;
                    hs_q <= 1'b0;
                end
                default: begin
                    state_q <= AOB_IDLE;
                    hs_q <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drivers, all registered
    // ----------------------------------------------------------------
    logic hs_mode_d;
    logic drv_high_d;
    logic drv_low_d;
    aob_hs_state_type next_view;

    always_comb begin
        hs_mode_d = hs_q || mode_level;
        // high data: on at load, held in hold until the falling edge sees empty
        drv_high_d = (state_q == AOB_LOAD_HIGH) ||
                     (state_q == AOB_HOLD_HIGH && !(fall_edge && tx_buffer_empty)) ||
                     (state_q == AOB_WAIT_HIGH && rise_edge && empty_q);
        drv_low_d = (state_q == AOB_LOAD_LOW && (rise_edge || !select_n_out)) ||
                    (state_q == AOB_HOLD_LOW && !(fall_edge && tx_buffer_empty));
        next_view = state_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            strobes_oe <= 1'b0;
            handshake_active <= 1'b0;
        end else begin
            strobes_oe <= hs_mode_d;
            handshake_active <= hs_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            select_n_out <= STROBE_IDLE;
            high_byte_enable_n_out <= STROBE_IDLE;
            low_byte_enable_n_out <= STROBE_IDLE;
        end else begin
            select_n_out <= !((next_view == AOB_WAIT_HIGH && rise_edge && empty_q) ||
                              (next_view == AOB_LOAD_HIGH && !rise_edge) ||
                              (next_view == AOB_LOAD_LOW &&
                               (rise_edge ? select_n_out : !select_n_out)));
            // the high enable outlives its data by half a period, up to the swap rise
            high_byte_enable_n_out <= !((next_view == AOB_WAIT_HIGH && rise_edge && empty_q) ||
                                        next_view == AOB_LOAD_HIGH ||
                                        next_view == AOB_HOLD_HIGH);
            low_byte_enable_n_out <= !((next_view == AOB_LOAD_LOW && (rise_edge || !select_n_out)) ||
                                       next_view == AOB_HOLD_LOW);
        end
    end

    // direct reads are combinationally gated in the pad ring; here they are
    // sampled once, so a read may see data one clock old
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            high_byte_oe <= 1'b0;
            low_byte_oe <= 1'b0;
            high_byte_out <= '0;
            low_byte_out <= '0;
        end else begin
            high_byte_out <= {overrange_q, sign_bit_q, result_q[RESULT_W-1:BYTE_W]};
            low_byte_out <= result_q[BYTE_W-1:0];
            if (hs_mode_d) begin
                high_byte_oe <= drv_high_d;
                low_byte_oe <= drv_low_d;
            end else begin
                high_byte_oe <= !select_n_in && !high_byte_enable_n_in;
                low_byte_oe <= !select_n_in && !low_byte_enable_n_in;
            end
        end
    end
endmodule

// ===== test/aob_result_output_assertions.sv
// concurrent checks on the ports of the result byte output block
module aob_result_output_checker
    import aob_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic conv_done,
    input wire logic conv_status,
    input wire logic handshake_active,
    input wire logic tx_buffer_empty,
    input wire logic select_n_in,
    input wire logic high_byte_enable_n_in,
    input wire logic low_byte_enable_n_in,
    input wire logic [aob_pkg::BYTE_W-1:0] low_byte_out,
    input wire logic low_byte_oe,
    input wire logic [aob_pkg::HIGH_W-1:0] high_byte_out,
    input wire logic high_byte_oe,
    input wire logic select_n_out,
    input wire logic high_byte_enable_n_out,
    input wire logic low_byte_enable_n_out,
    input wire logic strobes_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    logic direct;
    assign direct = !strobes_oe && !handshake_active;
    a_direct_low_drive: assert property (
        direct && $past(direct) |-> low_byte_oe == $past(!select_n_in && !low_byte_enable_n_in))
        else $error("low byte drive does not follow select and enable");
    a_direct_high_drive: assert property (
        direct && $past(direct) |-> high_byte_oe == $past(!select_n_in && !high_byte_enable_n_in))
        else $error("high byte drive does not follow select and enable");
    a_load_one_period: assert property (
        $fell(select_n_out) && strobes_oe |=> !select_n_out ##1 select_n_out)
        else $error("load strobe low time wrong");
    a_hs_pins_driven: assert property (
        handshake_active && $past(handshake_active) |-> strobes_oe)
        else $error("strobe pins not driven in handshake");
    a_hs_byte_exclusive: assert property (
        handshake_active |-> !(low_byte_oe && high_byte_oe))
        else $error("both bytes driven in handshake");
    a_latch_hold_status: assert property (
        !conv_status && $past(!conv_status) |-> $stable(low_byte_out) && $stable(high_byte_out))
        else $error("data changed while status low");
    a_hs_no_update: assert property (
        handshake_active && $past(handshake_active) |-> $stable(low_byte_out) && $stable(high_byte_out))
        else $error("data changed during handshake");
    a_status_fall: assert property (
        conv_done && conv_status && !handshake_active |-> ##[2:3] !conv_status)
        else $error("status did not fall after latching");
    a_high_hold_stall: assert property (
        handshake_active && high_byte_oe && !high_byte_enable_n_out && select_n_out && !tx_buffer_empty
        |=> high_byte_oe && !high_byte_enable_n_out)
        else $error("high byte not held while receiver busy");
    a_exit_idle: assert property (
        $fell(handshake_active) |-> select_n_out && high_byte_enable_n_out && low_byte_enable_n_out
        && !low_byte_oe && !high_byte_oe)
        else $error("handshake left with strobes or data active");
endmodule
bind aob_result_output aob_result_output_checker aob_result_output_checker_i (.*);

// ===== test/aob_uart_model.sv
// receiver buffer model that paces the two byte handshake
module aob_uart_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic load_n,
    input wire logic load_oe,
    input wire logic stall,
    output logic tx_buffer_empty
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] busy_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 4'h0;
        end else begin
            // the buffer counts as full from the moment load is seen low, then drains
            if (load_oe && !load_n) begin
                busy_q <= stall ? 4'hA : 4'h2;
            end else if (busy_q != 4'h0) begin
                busy_q <= busy_q - 4'h1;
            end
        end
    end
    // empty drops as soon as load goes low, as a real buffer would
    assign tx_buffer_empty = (busy_q == 4'h0) && !stall && !(load_oe && !load_n);
endmodule

// ===== test/test_adc_result_byte_output_handshake.sv
// self-checking bench for the result byte output block
module test_adc_result_byte_output_handshake
    import aob_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic resetn, conv_sign, conv_overrange, conv_done, autozero_end, convert_gate, mode_in, stall;
    logic select_n_in, high_byte_enable_n_in, low_byte_enable_n_in, tx_buffer_empty;
    logic [RESULT_W-1:0] conv_result;
    logic integrate_start, conv_status, handshake_active, low_byte_oe, high_byte_oe, strobes_oe;
    logic select_n_out, high_byte_enable_n_out, low_byte_enable_n_out, hi_q, lo_q;
    logic [BYTE_W-1:0] low_byte_out;
    logic [HIGH_W-1:0] high_byte_out;
    logic [13:0] lat, v;
    logic [7:0] exp_q[$];
    int n_errors, samples_checked, n_int, k;
    always #25 clk_sys = ~clk_sys;
    aob_result_output aob_result_output_i (.clk_sys(clk_sys), .resetn(resetn), .conv_result(conv_result),
        .conv_sign(conv_sign), .conv_overrange(conv_overrange), .conv_done(conv_done),
        .autozero_end(autozero_end), .convert_gate(convert_gate), .mode_in(mode_in),
        .tx_buffer_empty(tx_buffer_empty), .select_n_in(select_n_in),
        .high_byte_enable_n_in(high_byte_enable_n_in), .low_byte_enable_n_in(low_byte_enable_n_in),
        .integrate_start(integrate_start), .conv_status(conv_status), .handshake_active(handshake_active),
        .low_byte_out(low_byte_out), .low_byte_oe(low_byte_oe), .high_byte_out(high_byte_out),
        .high_byte_oe(high_byte_oe), .select_n_out(select_n_out),
        .high_byte_enable_n_out(high_byte_enable_n_out), .low_byte_enable_n_out(low_byte_enable_n_out),
        .strobes_oe(strobes_oe));
    aob_uart_model aob_uart_model_i (.clk_sys(clk_sys), .resetn(resetn), .load_n(select_n_out),
        .load_oe(strobes_oe), .stall(stall), .tx_buffer_empty(tx_buffer_empty));
    // ----------
    // checking
    // ----------
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic [7:0] nxt();
        return exp_q.size() ? exp_q.pop_front() : 8'hXX;
    endfunction
    always @(posedge clk_sys) begin
        if (high_byte_oe && !hi_q) chk("high byte", nxt(), {2'b00, high_byte_out});
        if (low_byte_oe && !lo_q) chk("low byte", nxt(), low_byte_out);
        hi_q = high_byte_oe;
        lo_q = low_byte_oe;
        n_int += integrate_start;
    end
    task automatic complete_run();
        chk("bytes never seen", 8'h00, 8'(exp_q.size()));
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------
    // stimulus
    // ----------
    task automatic rd(input bit sel, input bit hi, input bit lo);
        if (sel && hi) exp_q.push_back({2'b00, lat[13:8]});
        if (sel && lo) exp_q.push_back(lat[7:0]);
        @(posedge clk_sys);
        {select_n_in, high_byte_enable_n_in, low_byte_enable_n_in} <= {!sel, !hi, !lo};
        repeat (3) @(posedge clk_sys);
        {select_n_in, high_byte_enable_n_in, low_byte_enable_n_in} <= 3'h7;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic conv(input logic [13:0] cv, input bit take, input bit hold);
        {conv_overrange, conv_sign, conv_result} <= cv;
        convert_gate <= !hold;
        autozero_end <= 1'b1;
        @(posedge clk_sys);
        autozero_end <= 1'b0;
        if (hold) begin
            n_int = 0;
            repeat (20) @(posedge clk_sys);
            chk("starts while held", 8'h00, n_int[7:0]);
            convert_gate <= 1'b1;
        end
        k = 0;
        while (!integrate_start && k < 40) begin
            @(negedge clk_sys);
            k++;
        end
        // one converter period is two clk_sys cycles
        if (hold) chk("start delay", 8'h01,
            {7'h0, k >= 2 * START_DELAY_CYCLES && k <= 2 * START_DELAY_CYCLES + 2});
        repeat (5) @(posedge clk_sys);
        conv_done <= 1'b1;
        @(posedge clk_sys);
        conv_done <= 1'b0;
        if (take) lat = cv;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic hs_wait();
        k = 0;
        while (!handshake_active && k < 40) begin
            @(negedge clk_sys);
            k++;
        end
        while (handshake_active && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        repeat (3) @(posedge clk_sys);
    endtask
    initial begin
        {resetn, conv_result, conv_sign, conv_overrange, conv_done, autozero_end, mode_in, stall} = '0;
        {convert_gate, select_n_in, high_byte_enable_n_in, low_byte_enable_n_in} = 4'hF;
        {hi_q, lo_q, n_int, n_errors, samples_checked} = '0;
        k = $urandom(32'hC19267FD);
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        conv(14'($urandom()), 1'b1, 1'b1);
        rd(1, 1, 0);
        rd(1, 0, 1);
        rd(1, 1, 1);
        rd(0, 1, 1);
        $display("test direct reads done");
        // the rising edge of the held mode level is itself a trigger
        exp_q.push_back({2'b00, lat[13:8]});
        exp_q.push_back(lat[7:0]);
        mode_in <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("strobes driven", 8'h01, {7'h0, strobes_oe});
        hs_wait();
        repeat (2) begin
            v = 14'($urandom());
            exp_q.push_back({2'b00, v[13:8]});
            exp_q.push_back(v[7:0]);
            conv(v, 1'b1, 1'b0);
            hs_wait();
        end
        $display("test held mode handshake done");
        mode_in <= 1'b0;
        stall <= 1'b1;
        repeat (8) @(posedge clk_sys);
        exp_q.push_back({2'b00, lat[13:8]});
        exp_q.push_back(lat[7:0]);
        mode_in <= 1'b1;
        repeat (3) @(posedge clk_sys);
        mode_in <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk("load held off", 8'h01, {7'h0, select_n_out});
        conv(14'($urandom()), 1'b0, 1'b0);
        stall <= 1'b0;
        while (select_n_out && k < 100) begin
            @(negedge clk_sys);
            k++;
        end
        @(posedge clk_sys);
        stall <= 1'b1;
        repeat (12) @(posedge clk_sys);
        chk("high enable held", 8'h00, {7'h0, high_byte_enable_n_out});
        stall <= 1'b0;
        hs_wait();
        rd(1, 1, 1);
        $display("test triggered handshake done");
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        complete_run();
    end
endmodule
